// ---- rtl/accu_unit.sv ----
/*
  Conversion unit: accumulator, first stack level, code conversions and
  table operations on a word-addressed data memory.
  Assumes a memory that takes a request on mem_gnt and returns reads in order.
*/
`timescale 1ns/1ns
`default_nettype none
`include "accu_regs.svh"
// Notes on behaviour
// - Hex table expands to twice the words.
// - Count from stack, source acc, destination operand.
// - Digits map to ASCII 30-39 and 41-46.
// - Four accumulator digits become segment patterns.
// - Single word load fills lower 16 bits.
// - Reflected decode gives 10 BCD bits, rest zero.
// - 512 and 1024 count encoders need no correction.
// - Program subtracts 76 or 152 for 360/720.
// - Reorder digits from stack, order from accumulator.
// - Eight order nibbles each name source 1-8.
// - Order nibble zero or nine-F clears nibble.
// - Most significant duplicate order entry wins.
// - Reordered digits replace the order word.
// - Copy moves consecutive words to equal table.
// - Copy count from stack, at most FFF.
// - Copy source from accumulator, destination from operand.
// - Each load pushes accumulator into stack level.
// - Program converts octal addresses before table operations.
module accu_unit (
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  // Sequencer link
  accu_if.dev         link,
  // Data memory
  output logic        mem_req,
  output logic        mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input  wire logic   mem_gnt,
  input  wire logic   mem_rvalid,
  input  wire logic [15:0] mem_rdata
);
  accu_pkg::accu_unit_state_t s_ff;
  accu_pkg::accu_unit_state_t nxt_s;

  function automatic logic [7:0] ascii_of(input logic [3:0] d);
    if (d < 4'ha)
      return `ACCU_ASCII_DIGIT_BASE + {4'h0, d};
    return `ACCU_ASCII_ALPHA_BASE + {4'h0, d} - `ACCU_HEX_TEN;
  endfunction

  function automatic logic [6:0] seg_of(input logic [3:0] d);
    logic [6:0] p;
    unique case (d)
      4'h0: p = 7'h3f;
      4'h1: p = 7'h06;
      4'h2: p = 7'h5b;
      4'h3: p = 7'h4f;
      4'h4: p = 7'h66;
      4'h5: p = 7'h6d;
      4'h6: p = 7'h7d;
      4'h7: p = 7'h07;
      4'h8: p = 7'h7f;
      4'h9: p = 7'h6f;
      4'ha: p = 7'h77;
      4'hb: p = 7'h7c;
      4'hc: p = 7'h39;
      4'hd: p = 7'h5e;
      4'he: p = 7'h79;
      4'hf: p = 7'h71;
    endcase
    return p;
  endfunction

  function automatic logic [9:0] gray_bcd(input logic [15:0] g);
    logic [15:0] b;
    logic [11:0] d;
    int          i;
    b[15] = g[15];
    for (i = 14; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    d = accu_pkg::bin_to_bcd3(10'(b % `ACCU_BCD_SPAN));
    return d[`ACCU_BCD_W-1:0];
  endfunction

  function automatic logic [31:0] reorder(input logic [31:0] dig, input logic [31:0] ord);
    logic [31:0] r;
    logic [3:0]  o;
    logic        over;
    int          i;
    int          j;
    r = 32'h00000000;
    for (i = 0; i < 8; i++)
    begin
      o = ord[4*i+:4];
      over = 1'b0;
      for (j = i + 1; j < 8; j++)
      begin
        if (ord[4*j+:4] == o)
          over = 1'b1;
      end
      // A nibble left out here keeps the cleared value.
      if (o != 4'h0 && o <= `ACCU_ORDER_MAX && !over)
        r[4*i+:4] = dig[4*(int'(o)-1)+:4];
    end
    return r;
  endfunction

  logic        free;
  logic        push;
  logic        pop;
  logic        rd_issue;
  logic        slot;
  logic [15:0] hw;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    free = !s_ff.req || mem_gnt;
    push = mem_rvalid;
    pop = 1'b0;
    rd_issue = 1'b0;
    slot = s_ff.head ^ s_ff.cnt[0];
    hw = s_ff.buf_word[s_ff.head];
    if (free)
      nxt_s.req = 1'b0;
    if (push)
      nxt_s.buf_word[slot] = mem_rdata;
    unique case (s_ff.st)
      accu_pkg::accu_idle:
      begin
        if (link.cmd_valid)
        begin
          nxt_s.done = 1'b1;
          nxt_s.err = 1'b0;
          unique case (link.cmd_op)
            accu_pkg::accu_load_op, accu_pkg::octal_address_load_op:
            begin
              nxt_s.stk = s_ff.acc;
              nxt_s.acc = {16'h0000, link.cmd_data[`ACCU_LOW_WORD_W-1:0]};
            end
            accu_pkg::accu_load_double_op:
            begin
              nxt_s.stk = s_ff.acc;
              nxt_s.acc = link.cmd_data;
            end
            accu_pkg::segment_encode_op:
              nxt_s.acc = {1'b0, seg_of(s_ff.acc[15:12]), 1'b0, seg_of(s_ff.acc[11:8]),
                           1'b0, seg_of(s_ff.acc[7:4]), 1'b0, seg_of(s_ff.acc[3:0])};
            accu_pkg::accu_decode_op:
              nxt_s.acc = {{`ACCU_BCD_ZERO_W{1'b0}}, gray_bcd(s_ff.acc[15:0])};
            accu_pkg::digit_reorder_op:
              nxt_s.acc = reorder(s_ff.stk, s_ff.acc);
            accu_pkg::hex_to_ascii_op, accu_pkg::table_copy_op:
            begin
              nxt_s.is_hta = link.cmd_op == accu_pkg::hex_to_ascii_op;
              nxt_s.src = s_ff.acc[15:0];
              nxt_s.dst = link.cmd_addr;
              nxt_s.rd_left = s_ff.stk[15:0];
              nxt_s.half = 1'b0;
              if (nxt_s.is_hta)
                nxt_s.wr_left = {s_ff.stk[15:0], 1'b0};
              else
                nxt_s.wr_left = {1'b0, s_ff.stk[15:0]};
              if (!nxt_s.is_hta && s_ff.stk[15:0] > `ACCU_COPY_MAX)
                nxt_s.err = 1'b1;
              else
              begin
                nxt_s.done = 1'b0;
                nxt_s.st = accu_pkg::accu_run;
              end
            end
          endcase
        end
      end
      accu_pkg::accu_run:
      begin
        // Writes go first so the buffer drains; a stalled write blocks reads.
        if (free && s_ff.cnt != 2'h0)
        begin
          nxt_s.req = 1'b1;
          nxt_s.we = 1'b1;
          nxt_s.addr = s_ff.dst;
          nxt_s.dst = s_ff.dst + 16'h0001;
          nxt_s.wr_left = s_ff.wr_left - 17'h00001;
          if (s_ff.is_hta)
          begin
            if (s_ff.half)
              nxt_s.wdata = {ascii_of(hw[7:4]), ascii_of(hw[3:0])};
            else
              nxt_s.wdata = {ascii_of(hw[15:12]), ascii_of(hw[11:8])};
            pop = s_ff.half;
            nxt_s.half = !s_ff.half;
          end
          else
          begin
            nxt_s.wdata = hw;
            pop = 1'b1;
          end
        end
        else if (free && s_ff.rd_left != 16'h0000 &&
                 ({1'b0, s_ff.cnt} + {1'b0, s_ff.rd_out}) < {1'b0, `ACCU_BUF_DEPTH})
        begin
          rd_issue = 1'b1;
          nxt_s.req = 1'b1;
          nxt_s.we = 1'b0;
          nxt_s.addr = s_ff.src;
          nxt_s.src = s_ff.src + 16'h0001;
          nxt_s.rd_left = s_ff.rd_left - 16'h0001;
        end
        else if (free && s_ff.rd_left == 16'h0000 && s_ff.wr_left == 17'h00000 &&
                 s_ff.rd_out == 2'h0)
        begin
          nxt_s.done = 1'b1;
          nxt_s.st = accu_pkg::accu_idle;
        end
      end
      default:
        nxt_s.st = accu_pkg::accu_idle;
    endcase
    if (pop)
      nxt_s.head = !s_ff.head;
    nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
    nxt_s.rd_out = s_ff.rd_out + {1'b0, rd_issue} - {1'b0, push};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign link.cmd_ready = s_ff.st == accu_pkg::accu_idle;
  assign link.rsp_done = s_ff.done;
  assign link.rsp_err = s_ff.err;
  assign link.rsp_acc = s_ff.acc;
  assign link.rsp_stk = s_ff.stk;
  assign mem_req = s_ff.req;
  assign mem_we = s_ff.we;
  assign mem_addr = s_ff.addr;
  assign mem_wdata = s_ff.wdata;
endmodule // accu_unit
`default_nettype wire

// ---- rtl/accu_regs.svh ----
/*
  Constants of the accumulator conversion unit and its sequencer end.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef ACCU_REGS_SVH
`define ACCU_REGS_SVH
`define ACCU_ASCII_DIGIT_BASE 8'h30
`define ACCU_ASCII_ALPHA_BASE 8'h41
`define ACCU_HEX_TEN          8'h0a
`define ACCU_LOW_WORD_W       16
`define ACCU_BCD_W            10
`define ACCU_BCD_ZERO_W       22
`define ACCU_BCD_SPAN         16'd1000
`define ACCU_COPY_MAX         16'h0fff
`define ACCU_ORDER_MAX        4'h8
`define ACCU_FIX_360          11'd76
`define ACCU_FIX_720          11'd152
`define ACCU_BUF_DEPTH        2'h2
`endif

// ---- rtl/accu_pkg.sv ----
/*
  Types and shared decoding of the accumulator conversion unit.
  Assumes the constants header sits beside it.
*/
`include "accu_regs.svh"
package accu_pkg;
  typedef enum logic [2:0] {
    accu_load_op, accu_load_double_op, octal_address_load_op, hex_to_ascii_op,
    segment_encode_op, accu_decode_op, digit_reorder_op, table_copy_op
  } accu_op_t;
  typedef enum logic [1:0] {accu_res_direct, accu_res_360, accu_res_720} accu_res_t;
  typedef enum logic [1:0] {accu_idle, accu_run} accu_state_t;
  typedef struct packed {
    accu_state_t      st;
    logic [31:0]      acc;
    logic [31:0]      stk;
    logic [15:0]      src;
    logic [15:0]      dst;
    logic [15:0]      rd_left;
    logic [16:0]      wr_left;
    logic [1:0]       rd_out;
    logic [1:0][15:0] buf_word;
    logic             head;
    logic [1:0]       cnt;
    logic             half;
    logic             is_hta;
    logic             req;
    logic             we;
    logic [15:0]      addr;
    logic [15:0]      wdata;
    logic             done;
    logic             err;
  } accu_unit_state_t;
  typedef struct packed {
    logic        busy;
    logic        held;
    accu_op_t    op;
    logic [31:0] data;
    logic [15:0] addr;
    logic        done;
    logic        err;
    logic [31:0] acc;
    logic [11:0] fixed;
  } accu_seq_state_t;

  // Binary below one thousand to three BCD digits by shift and add three.
  function automatic logic [11:0] bin_to_bcd3(input logic [9:0] v);
    logic [11:0] b;
    int          i;
    int          k;
    b = 12'h000;
    for (i = 9; i >= 0; i--)
    begin
      for (k = 0; k < 3; k++)
      begin
        if (b[4*k+:4] > 4'h4)
          b[4*k+:4] = b[4*k+:4] + 4'h3;
      end
      b = {b[10:0], v[i]};
    end
    return b;
  endfunction
endpackage

// ---- rtl/accu_if.sv ----
/*
  Link between the instruction sequencer and the conversion unit.
  Assumes both ends run on the same clock; commands use valid and ready.
*/
`timescale 1ns/1ns
`default_nettype none
interface accu_if;
  logic               cmd_valid;
  logic               cmd_ready;
  accu_pkg::accu_op_t cmd_op;
  logic [31:0]        cmd_data;
  logic [15:0]        cmd_addr;
  logic               rsp_done;
  logic               rsp_err;
  logic [31:0]        rsp_acc;
  logic [31:0]        rsp_stk;
  modport dev (input cmd_valid, cmd_op, cmd_data, cmd_addr,
               output cmd_ready, rsp_done, rsp_err, rsp_acc, rsp_stk);
  modport seq (output cmd_valid, cmd_op, cmd_data, cmd_addr,
               input cmd_ready, rsp_done, rsp_err, rsp_acc, rsp_stk);
endinterface
`default_nettype wire

// ---- rtl/accu_seq.sv ----
/*
  Sequencer end: passes user commands to the unit, converts octal
  addresses and corrects decoded positions for 360 and 720 count encoders.
  Assumes the user keeps count-then-address order for table operations.
*/
`timescale 1ns/1ns
`default_nettype none
`include "accu_regs.svh"
module accu_seq (
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  // Unit link
  accu_if.seq         link,
  // User commands
  input  wire logic   usr_valid,
  output logic        usr_ready,
  input  wire accu_pkg::accu_op_t usr_op,
  input  wire logic [31:0] usr_data,
  input  wire logic [15:0] usr_addr,
  input  wire accu_pkg::accu_res_t enc_res,
  // User results
  output logic        usr_done,
  output logic        usr_err,
  output logic [31:0] usr_acc,
  output logic [11:0] usr_fixed
);
  accu_pkg::accu_seq_state_t s_ff;
  accu_pkg::accu_seq_state_t nxt_s;

  function automatic logic [11:0] fix_bcd(input logic [11:0] d, input accu_pkg::accu_res_t r);
    logic [10:0] b;
    logic [10:0] sub;
    // Each digit is widened first so that the hundreds product cannot wrap.
    b = 11'(d[11:8]) * 11'd100 + 11'(d[7:4]) * 11'd10 + {7'h00, d[3:0]};
    unique case (r)
      accu_pkg::accu_res_360: sub = `ACCU_FIX_360;
      accu_pkg::accu_res_720: sub = `ACCU_FIX_720;
      default: sub = 11'd0;
    endcase
    if (b < sub)
      b = b + 11'(`ACCU_BCD_SPAN);
    b = b - sub;
    return accu_pkg::bin_to_bcd3(b[9:0]);
  endfunction

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (!s_ff.busy && usr_valid)
    begin
      nxt_s.busy = 1'b1;
      nxt_s.held = 1'b1;
      nxt_s.op = usr_op;
      nxt_s.data = usr_data;
      nxt_s.addr = usr_addr;
      if (usr_op == accu_pkg::octal_address_load_op)
        nxt_s.data = {20'h00000, usr_data[14:12], usr_data[10:8],
                      usr_data[6:4], usr_data[2:0]};
    end
    if (s_ff.held && link.cmd_ready)
      nxt_s.held = 1'b0;
    if (s_ff.busy && !s_ff.held && link.rsp_done)
    begin
      nxt_s.busy = 1'b0;
      nxt_s.done = 1'b1;
      nxt_s.err = link.rsp_err;
      nxt_s.acc = link.rsp_acc;
      if (s_ff.op == accu_pkg::accu_decode_op)
        nxt_s.fixed = fix_bcd({2'b00, link.rsp_acc[9:0]}, enc_res);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign usr_ready = !s_ff.busy;
  assign link.cmd_valid = s_ff.held;
  assign link.cmd_op = s_ff.op;
  assign link.cmd_data = s_ff.data;
  assign link.cmd_addr = s_ff.addr;
  assign usr_done = s_ff.done;
  assign usr_err = s_ff.err;
  assign usr_acc = s_ff.acc;
  assign usr_fixed = s_ff.fixed;
endmodule // accu_seq
`default_nettype wire

// ---- tb/accu_link_sva.sv ----
/*
  Checker for the link between the sequencer end and the conversion unit.
  Assumes it sees the link signals on ref_clk, with nrst synchronous low.
*/
`timescale 1ns/1ns
`default_nettype none
module accu_link_sva (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               nrst,
  // Link
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire accu_pkg::accu_op_t cmd_op,
  input wire logic [31:0]        cmd_data,
  input wire logic               rsp_done,
  input wire logic               rsp_err,
  input wire logic [31:0]        rsp_acc,
  input wire logic [31:0]        rsp_stk
);
  logic        take;
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Sources met again further down are dropped, so the most significant one wins.
  function automatic logic [31:0] shuf(input logic [31:0] s, input logic [31:0] o);
    logic [31:0] r;
    logic [8:0]  used;
    int          p;
    int          k;
    r = 32'h00000000;
    used = 9'h000;
    for (p = 7; p >= 0; p--)
    begin
      k = o[4*p+:4];
      if (k >= 1 && k <= 8 && !used[k])
      begin
        used[k] = 1'b1;
        r[4*p+:4] = s[4*(k-1)+:4];
      end
    end
    return r;
  endfunction

  load_low_a: assert property (take && cmd_op == accu_pkg::accu_load_op |=>
    rsp_acc[31:16] == 16'h0000 && rsp_acc[15:0] == $past(cmd_data[15:0]))
    else $error("single load not in low word");
  load_push_a: assert property (take && cmd_op == accu_pkg::accu_load_op |=>
    rsp_stk == $past(rsp_acc)) else $error("load did not push accumulator");
  octal_load_a: assert property (take && cmd_op == accu_pkg::octal_address_load_op |=>
    rsp_acc == {20'h00000, $past(cmd_data[11:0])} && $past(cmd_data[31:12]) == 20'h00000)
    else $error("octal address load wrong");
  seg_byte_a: assert property (take && cmd_op == accu_pkg::segment_encode_op |=>
    (rsp_acc & 32'h80808080) == 32'h00000000) else $error("segment bit 7 set");
  decode_zero_a: assert property (take && cmd_op == accu_pkg::accu_decode_op |=>
    rsp_acc[31:10] == 22'h000000) else $error("decode upper bits not zero");
  reorder_result_a: assert property (take && cmd_op == accu_pkg::digit_reorder_op |=>
    rsp_acc == shuf($past(rsp_stk), $past(rsp_acc))) else $error("reorder result wrong");
  reorder_stack_a: assert property (take && cmd_op == accu_pkg::digit_reorder_op |=>
    $stable(rsp_stk)) else $error("reorder disturbed stack");
  copy_limit_a: assert property (take && cmd_op == accu_pkg::table_copy_op &&
    rsp_stk[15:0] > 16'h0fff |-> ##[1:4] rsp_done ##[0:1] rsp_err)
    else $error("oversized copy not refused");
  quick_done_a: assert property (take && cmd_op != accu_pkg::table_copy_op &&
    cmd_op != accu_pkg::hex_to_ascii_op |=> rsp_done) else $error("late done");

  cover property (take && cmd_op == accu_pkg::digit_reorder_op);
  cover property (take && cmd_op == accu_pkg::hex_to_ascii_op);
  cover property (rsp_done && rsp_err);
endmodule // accu_link_sva
`default_nettype wire

// ---- tb/tb_accum_code_conversion_unit.sv ----
/*
  Bench: sequencer and unit joined by their link, plus a word memory that
  grants every other cycle. Assumes the design and checker compile first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_accum_code_conversion_unit;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    accu_pkg::accu_op_t op;
    logic [1:0] res;
    logic [31:0] exp;
    logic [11:0] fix;
  } accu_row_t;
  accu_row_t rows [13] = '{
    '{32'h0, 32'hdeadbeef, accu_pkg::accu_load_op, 2'h0, 32'h0000beef, 12'h0},
    '{32'h0, 32'hdeadbeef, accu_pkg::accu_load_double_op, 2'h0, 32'hdeadbeef, 12'h0},
    '{32'h0, 32'h2000, accu_pkg::octal_address_load_op, 2'h0, 32'h400, 12'h0},
    '{32'h0, 32'h7777, accu_pkg::octal_address_load_op, 2'h0, 32'hfff, 12'h0},
    '{32'h0, 32'h8a3e, accu_pkg::segment_encode_op, 2'h0, 32'h7f774f79, 12'h0},
    '{32'h0, 32'h2c50, accu_pkg::segment_encode_op, 2'h0, 32'h5b396d3f, 12'h0},
    '{32'h0, 32'h214, accu_pkg::accu_decode_op, 2'h0, 32'h199, 12'h0},
    '{32'h0, 32'h200, accu_pkg::accu_decode_op, 2'h0, 32'h023, 12'h0},
    '{32'h0, 32'h1ba, accu_pkg::accu_decode_op, 2'h1, 32'h300, 12'h224},
    '{32'h0, 32'h1ba, accu_pkg::accu_decode_op, 2'h2, 32'h300, 12'h148},
    '{32'hfedcba98, 32'h12345678, accu_pkg::digit_reorder_op, 2'h0, 32'h89abcdef, 12'h0},
    '{32'hfedcba98, 32'h19a30b0f, accu_pkg::digit_reorder_op, 2'h0, 32'h800a0000, 12'h0},
    '{32'hfedcba98, 32'h11112222, accu_pkg::digit_reorder_op, 2'h0, 32'h80009000, 12'h0}};
  logic ref_clk;
  logic nrst = 1'b0;
  logic usr_valid = 1'b0;
  logic usr_ready, usr_done, usr_err, mem_req, mem_we;
  logic mem_gnt = 1'b0;
  logic mem_rvalid = 1'b0;
  accu_pkg::accu_op_t usr_op = accu_pkg::accu_load_op;
  accu_pkg::accu_res_t enc_res = accu_pkg::accu_res_direct;
  logic [31:0] usr_data = 32'h00000000;
  logic [31:0] usr_acc;
  logic [15:0] usr_addr = 16'h0000;
  logic [15:0] mem_addr, mem_wdata;
  logic [15:0] mem_rdata = 16'h0000;
  logic [11:0] usr_fixed;
  logic [15:0] mem [256];
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;

  accu_if lk ();
  accu_unit accu_unit_i (.ref_clk(ref_clk), .nrst(nrst), .link(lk), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  accu_seq accu_seq_i (.ref_clk(ref_clk), .nrst(nrst), .link(lk), .usr_valid(usr_valid),
    .usr_ready(usr_ready), .usr_op(usr_op), .usr_data(usr_data), .usr_addr(usr_addr),
    .enc_res(enc_res), .usr_done(usr_done), .usr_err(usr_err), .usr_acc(usr_acc),
    .usr_fixed(usr_fixed));
  accu_link_sva accu_link_sva_i (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(lk.cmd_valid),
    .cmd_ready(lk.cmd_ready), .cmd_op(lk.cmd_op), .cmd_data(lk.cmd_data),
    .rsp_done(lk.rsp_done), .rsp_err(lk.rsp_err), .rsp_acc(lk.rsp_acc), .rsp_stk(lk.rsp_stk));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Grants every other cycle so the unit's buffer must ride out stalls.
  always @(posedge ref_clk)
  begin
    cyc++;
    mem_gnt <= ~mem_gnt;
    mem_rvalid <= mem_req && mem_gnt && !mem_we;
    mem_rdata <= mem[mem_addr[7:0]];
    if (mem_req && mem_gnt && mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
    if (cyc == 40000)
    begin
      errors++;
      results();
    end
  end

  function automatic logic [7:0] asc(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic run(input accu_pkg::accu_op_t o, input logic [31:0] d, input logic [15:0] a);
    int n;
    usr_valid <= 1'b1;
    usr_op <= o;
    usr_data <= d;
    usr_addr <= a;
    do @(posedge ref_clk); while (usr_ready !== 1'b1);
    usr_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (usr_done !== 1'b1 && n < 20000);
    // A command that never finishes is a failure even if later checks agree.
    if (usr_done !== 1'b1)
      errors++;
  endtask

  task automatic table_op(input accu_pkg::accu_op_t o, input logic [15:0] cnt,
    input logic [15:0] src, input logic [15:0] dst);
    run(accu_pkg::accu_load_op, {16'h0000, cnt}, 16'h0000);
    run(accu_pkg::accu_load_op, {16'h0000, src}, 16'h0000);
    run(o, 32'h00000000, dst);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'h5a00 ^ 16'(i);
    mem[48] = 16'h0123;
    mem[49] = 16'h4567;
    mem[50] = 16'h89ab;
    mem[51] = 16'hcdef;
    repeat (6) @(posedge ref_clk);
    chk("usr_ready in reset", {31'h0, usr_ready}, 32'h1);
    chk("usr_acc in reset", usr_acc, 32'h0);
    nrst <= 1'b1;
    foreach (rows[t])
    begin
      enc_res <= accu_pkg::accu_res_t'(rows[t].res);
      run(accu_pkg::accu_load_double_op, rows[t].a, 16'h0000);
      run(accu_pkg::accu_load_double_op, rows[t].b, 16'h0000);
      run(rows[t].op, rows[t].b, 16'h0000);
      chk("usr_acc", usr_acc, rows[t].exp);
      if (rows[t].res != 2'h0)
        chk("usr_fixed", {20'h0, usr_fixed}, {20'h0, rows[t].fix});
      $display("row %0d finished", t);
    end
    table_op(accu_pkg::table_copy_op, 16'h0004, 16'h0010, 16'h0020);
    for (int i = 0; i < 5; i++)
      chk("copy word", {16'h0, mem[32+i]}, {16'h0, 16'h5a00 ^ 16'((i < 4) ? 16 + i : 36)});
    chk("copy err", {31'h0, usr_err}, 32'h0);
    $display("copy test finished");
    table_op(accu_pkg::hex_to_ascii_op, 16'h0004, 16'h0030, 16'h0040);
    for (int i = 0; i < 8; i++)
      chk("ascii word", {16'h0, mem[64+i]}, {16'h0, asc(4'(2*i)), asc(4'(2*i+1))});
    chk("past ascii table", {16'h0, mem[72]}, {16'h0, 16'h5a48});
    $display("hex to ascii test finished");
    table_op(accu_pkg::table_copy_op, 16'h1000, 16'h0010, 16'h0080);
    chk("oversized err", {31'h0, usr_err}, 32'h1);
    chk("oversized untouched", {16'h0, mem[128]}, {16'h0, 16'h5a80});
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk("usr_acc after reset", usr_acc, 32'h0);
    chk("usr_err after reset", {31'h0, usr_err}, 32'h0);
    chk("usr_ready after reset", {31'h0, usr_ready}, 32'h1);
    $display("second reset test finished");
    table_op(accu_pkg::table_copy_op, 16'h0fff, 16'h0000, 16'h1000);
    chk("largest copy err", {31'h0, usr_err}, 32'h0);
    $display("copy limit test finished");
    results();
  end
endmodule // tb_accum_code_conversion_unit
`default_nettype wire
